// [common/cau_pkg.sv]
// Shared constants and types for the compact ALU execute block.
// Assumes a single core clock domain and an AHB-Lite register slave.
package cau_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0]  OFS_INSTR   = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_REGSEL  = 8'h08;
    localparam logic [7:0]  OFS_REGDATA = 8'h0C;

    // Status word field positions
    localparam int          ST_FLAGS_LSB = 0;
    localparam int          ST_BUSY_BIT  = 4;
    localparam int          ST_UNDEF_BIT = 5;

    // Reset values
    localparam logic [15:0] RST_INSTR  = 16'h0000;
    localparam logic [3:0]  RST_FLAGS  = 4'h0;
    localparam logic [3:0]  RST_REGSEL = 4'h0;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    // Bus encodings
    localparam logic [2:0]  SIZE_WORD = 3'h2;
    localparam logic        RESP_OKAY = 1'b0;

    // Instruction encodings
    localparam logic [5:0]  DP_GROUP = 6'h10;
    localparam logic [3:0]  OPC_MUL  = 4'hD;
    localparam logic [3:0]  OPC_INV  = 4'hF;
    localparam logic [3:0]  OPC_NEG  = 4'h9;
    localparam logic [3:0]  OPC_OR   = 4'hC;
    localparam logic [7:0]  HI_COPY  = 8'h46;
    localparam logic [9:0]  LO_COPY  = 10'h070;

    // Register file shape
    localparam int          REG_COUNT = 16;

    typedef enum logic [2:0] {
        OP_NONE    = 3'b000,
        OP_COPY_LO = 3'b001,
        OP_COPY_HI = 3'b010,
        OP_MUL     = 3'b011,
        OP_INV     = 3'b100,
        OP_NEG     = 3'b101,
        OP_OR      = 3'b110
    } cau_op_type;

    typedef struct packed {
        cau_op_type op;
        logic [3:0] srcIdx;
        logic [3:0] dstIdx;
    } cau_dec_type;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } cau_flags_type;

    typedef enum logic [2:0] {
        CORE_IDLE   = 3'b000,
        CORE_RD_SRC = 3'b001,
        CORE_RD_DST = 3'b010,
        CORE_EXEC   = 3'b011,
        CORE_MUL    = 3'b100
    } cau_core_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b10
    } cau_bus_type;

endpackage : cau_pkg

// [core/cau_regfile.sv]
// Sixteen-word general register file for the execute block.
// Assumes one write and one read per cycle; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module cau_regfile (
    // Clock, reset and freeze
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Write port
    input  wire logic        wrEn,
    input  wire logic [3:0]  wrAddr,
    input  wire logic [31:0] wrData,
    // Read port, data one cycle after the address
    input  wire logic [3:0]  rdAddr,
    output logic      [31:0] rdData
);
    logic [31:0] mem [0:cau_pkg::REG_COUNT-1];

    // Storage; contents are left undefined by reset, like any core register
    always_ff @(posedge sys_clk) begin
        if (ce && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Registered read; a same-cycle write shows up one access later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData <= cau_pkg::RST_WORD;
        end else if (ce) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : cau_regfile
`default_nettype wire

// [core/cau_top.sv]
// Execute datapath for copy, multiply, invert, negate and OR operations.
// Assumes an AHB-Lite master on the single core clock; no other partner.
// What this block does
// - Low copy writes source, sets N and Z, clears C and V.
// - High copy writes source and leaves all four flags alone.
// - High copy destination index is dest_high_select over dest_reg.
// - High copy source index is src_high_select over src_reg.
// - Both select bits zero give nonflag_low_copy between low registers.
// - That low-low form is undefined on old revisions; newer behaviour used.
// - product_low_word writes low 32 product bits back to dest_reg.
// - Low product word is identical for signed and unsigned operands.
// - product_low_word sets N and Z from its result.
// - product_low_word leaves C unchanged.
// - Multiplier early termination looks at the dest_reg operand.
// - Multiply is correct when dest_reg and src_reg are the same.
// - invert_copy writes ones complement, sets N and Z, keeps C, V.
// - zero_minus_operand writes negation, C is not borrow, V overflow.
// - bitwise_union writes OR, sets N and Z, keeps C and V.
// - Low copy is bits 15..6 equal 0001110000, flags from value.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module cau_top (
    // Clock, reset and freeze
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp
);
    // Decode one instruction halfword into operation and register indices
    function automatic cau_pkg::cau_dec_type decodeInstr(
        input logic [15:0] ins
    );
        cau_pkg::cau_dec_type d;
        d.op     = cau_pkg::OP_NONE;
        d.srcIdx = {1'b0, ins[5:3]};
        d.dstIdx = {1'b0, ins[2:0]};
        if (ins[15:10] == cau_pkg::DP_GROUP) begin
            case (ins[9:6])
                cau_pkg::OPC_MUL: d.op = cau_pkg::OP_MUL;
                cau_pkg::OPC_INV: d.op = cau_pkg::OP_INV;
                cau_pkg::OPC_NEG: d.op = cau_pkg::OP_NEG;
                cau_pkg::OPC_OR:  d.op = cau_pkg::OP_OR;
                default:          d.op = cau_pkg::OP_NONE;
            endcase
        end else if (ins[15:8] == cau_pkg::HI_COPY) begin
            // Both selects zero decode as the low-low copy too
            d.op     = cau_pkg::OP_COPY_HI;
            d.srcIdx = {ins[6], ins[5:3]};
            d.dstIdx = {ins[7], ins[2:0]};
        end else if (ins[15:6] == cau_pkg::LO_COPY) begin
            d.op = cau_pkg::OP_COPY_LO;
        end
        return d;
    endfunction : decodeInstr

    cau_pkg::cau_bus_type   busState;
    cau_pkg::cau_core_type  coreState;
    cau_pkg::cau_dec_type   opReg;
    cau_pkg::cau_dec_type   busDec;
    cau_pkg::cau_flags_type flagsReg;
    cau_pkg::cau_flags_type aluFlags;
    logic [7:0]             busAddr;
    logic                   busWrite;
    logic                   busWordOk;
    logic                   busWr;
    logic                   accept;
    logic                   startCore;
    logic                   undefSet;
    logic                   undefClr;
    logic                   undefReg;
    logic [15:0]            instrReg;
    logic [3:0]             regSel;
    logic [31:0]            srcVal;
    logic [31:0]            dstVal;
    logic [31:0]            mulAcc;
    logic [31:0]            mulCand;
    logic [31:0]            mulRem;
    logic [31:0]            aluRes;
    logic [32:0]            negDiff;
    logic [31:0]            readMux;
    logic                   coreWr;
    logic                   wrEn;
    logic [3:0]             wrAddr;
    logic [31:0]            wrData;
    logic [3:0]             rdAddr;
    logic [31:0]            rdData;

    // Bus request decode
    assign accept = hsel && htrans[1] && hready && (busState == cau_pkg::BUS_IDLE);
    assign busWr  = (busState == cau_pkg::BUS_DONE) && busWrite && busWordOk;
    assign busDec = decodeInstr(hwdata[15:0]);
    assign startCore = busWr && (busAddr == cau_pkg::OFS_INSTR)
                       && (busDec.op != cau_pkg::OP_NONE);
    assign undefSet  = busWr && (busAddr == cau_pkg::OFS_INSTR)
                       && (busDec.op == cau_pkg::OP_NONE);
    assign undefClr  = busWr && (busAddr == cau_pkg::OFS_STATUS)
                       && hwdata[cau_pkg::ST_UNDEF_BIT];

    // Bus phase tracker; every access waits for the core to be idle,
    // which keeps the single register-file read port free of conflicts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busState  <= cau_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
            busAddr   <= 8'h00;
            busWrite  <= 1'b0;
            busWordOk <= 1'b0;
        end else if (ce) begin
            unique case (busState)
                cau_pkg::BUS_IDLE: begin
                    if (accept) begin
                        busAddr   <= haddr[7:0];
                        busWrite  <= hwrite;
                        busWordOk <= (hsize == cau_pkg::SIZE_WORD);
                        hreadyout <= 1'b0;
                        busState  <= cau_pkg::BUS_WAIT;
                    end
                end
                cau_pkg::BUS_WAIT: begin
                    if (coreState == cau_pkg::CORE_IDLE) begin
                        busState <= cau_pkg::BUS_DONE;
                    end
                end
                cau_pkg::BUS_DONE: begin
                    hreadyout <= 1'b1;
                    busState  <= cau_pkg::BUS_IDLE;
                end
                default: begin
                    hreadyout <= 1'b1;
                    busState  <= cau_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Read data multiplexer; unmapped offsets read as zero
    always_comb begin
        readMux = cau_pkg::RST_WORD;
        case (busAddr)
            cau_pkg::OFS_INSTR:   readMux[15:0] = instrReg;
            cau_pkg::OFS_STATUS: begin
                readMux[cau_pkg::ST_FLAGS_LSB +: 4] = flagsReg;
                readMux[cau_pkg::ST_BUSY_BIT] = (coreState != cau_pkg::CORE_IDLE);
                readMux[cau_pkg::ST_UNDEF_BIT] = undefReg;
            end
            cau_pkg::OFS_REGSEL:  readMux[3:0] = regSel;
            cau_pkg::OFS_REGDATA: readMux = rdData;
            default:              readMux = cau_pkg::RST_WORD;
        endcase
    end

    // Read data register, loaded in the last data-phase cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= cau_pkg::RST_WORD;
        end else if (ce && busState == cau_pkg::BUS_DONE && !busWrite) begin
            hrdata <= readMux;
        end
    end

    // Response is always OKAY; kept in a flop for a clean output
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hresp <= cau_pkg::RESP_OKAY;
        end else if (ce) begin
            hresp <= cau_pkg::RESP_OKAY;
        end
    end

    // Software-visible control registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            instrReg <= cau_pkg::RST_INSTR;
            regSel   <= cau_pkg::RST_REGSEL;
            opReg    <= '{op: cau_pkg::OP_NONE, srcIdx: 4'h0, dstIdx: 4'h0};
        end else if (ce && busWr) begin
            if (busAddr == cau_pkg::OFS_INSTR) begin
                instrReg <= hwdata[15:0];
                opReg    <= busDec;
            end
            if (busAddr == cau_pkg::OFS_REGSEL) begin
                regSel <= hwdata[3:0];
            end
        end
    end

    // Undefined-encoding flag; a new event beats a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            undefReg <= 1'b0;
        end else if (ce) begin
            undefReg <= undefSet | (undefReg & ~undefClr);
        end
    end

    // Core sequencer: read source, read destination, then execute
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            coreState <= cau_pkg::CORE_IDLE;
        end else if (ce) begin
            unique case (coreState)
                cau_pkg::CORE_IDLE: begin
                    if (startCore) begin
                        coreState <= cau_pkg::CORE_RD_SRC;
                    end
                end
                cau_pkg::CORE_RD_SRC: coreState <= cau_pkg::CORE_RD_DST;
                cau_pkg::CORE_RD_DST: coreState <= cau_pkg::CORE_EXEC;
                cau_pkg::CORE_EXEC: begin
                    if (opReg.op == cau_pkg::OP_MUL) begin
                        coreState <= cau_pkg::CORE_MUL;
                    end else begin
                        coreState <= cau_pkg::CORE_IDLE;
                    end
                end
                cau_pkg::CORE_MUL: begin
                    if (mulRem == 32'h0000_0000) begin
                        coreState <= cau_pkg::CORE_IDLE;
                    end
                end
                default: coreState <= cau_pkg::CORE_IDLE;
            endcase
        end
    end

    // Operand capture; both values are latched before any write-back,
    // so a shared source and destination register is harmless
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            srcVal <= cau_pkg::RST_WORD;
            dstVal <= cau_pkg::RST_WORD;
        end else if (ce) begin
            if (coreState == cau_pkg::CORE_RD_DST) begin
                srcVal <= rdData;
            end
            if (coreState == cau_pkg::CORE_EXEC) begin
                dstVal <= rdData;
            end
        end
    end

    // Shift-add multiplier; stops as soon as the destination operand
    // has no set bits left (unsigned early termination)
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mulAcc  <= cau_pkg::RST_WORD;
            mulCand <= cau_pkg::RST_WORD;
            mulRem  <= cau_pkg::RST_WORD;
        end else if (ce) begin
            if (coreState == cau_pkg::CORE_EXEC) begin
                mulAcc  <= cau_pkg::RST_WORD;
                mulCand <= srcVal;
                mulRem  <= rdData;
            end else if (coreState == cau_pkg::CORE_MUL && mulRem != 32'h0000_0000) begin
                // Only the low word is ever formed, so sign does not matter
                if (mulRem[0]) begin
                    mulAcc <= mulAcc + mulCand;
                end
                mulCand <= {mulCand[30:0], 1'b0};
                mulRem  <= {1'b0, mulRem[31:1]};
            end
        end
    end

    // Result and flag computation; destination value is rdData in EXEC
    always_comb begin
        aluFlags = flagsReg;
        aluRes   = srcVal;
        negDiff  = {1'b0, cau_pkg::RST_WORD} - {1'b0, srcVal};
        case (opReg.op)
            cau_pkg::OP_COPY_LO: begin
                aluRes     = srcVal;
                aluFlags.c = 1'b0;
                aluFlags.v = 1'b0;
            end
            cau_pkg::OP_COPY_HI: aluRes = srcVal;
            cau_pkg::OP_INV:     aluRes = ~srcVal;
            cau_pkg::OP_NEG: begin
                aluRes     = negDiff[31:0];
                aluFlags.c = ~negDiff[32];
                aluFlags.v = srcVal[31] & negDiff[31];
            end
            cau_pkg::OP_OR:      aluRes = rdData | srcVal;
            cau_pkg::OP_MUL:     aluRes = mulAcc;
            default:             aluRes = srcVal;
        endcase
        // N and Z follow the result except for the high copy
        if (opReg.op != cau_pkg::OP_COPY_HI) begin
            aluFlags.n = aluRes[31];
            aluFlags.z = (aluRes == 32'h0000_0000);
        end
    end

    // Write-back selection between core and bus
    assign coreWr = ((coreState == cau_pkg::CORE_EXEC)
                     && (opReg.op != cau_pkg::OP_MUL))
                    || ((coreState == cau_pkg::CORE_MUL)
                     && (mulRem == 32'h0000_0000));
    assign wrEn   = coreWr || (busWr && busAddr == cau_pkg::OFS_REGDATA);
    assign wrAddr = coreWr ? opReg.dstIdx : regSel;
    assign wrData = coreWr ? aluRes : hwdata;
    assign rdAddr = (coreState == cau_pkg::CORE_RD_SRC) ? opReg.srcIdx :
                    (coreState == cau_pkg::CORE_RD_DST) ? opReg.dstIdx :
                    regSel;

    // Condition flags; the high copy passes them through untouched
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flagsReg <= cau_pkg::RST_FLAGS;
        end else if (ce) begin
            if (busWr && busAddr == cau_pkg::OFS_STATUS) begin
                flagsReg <= hwdata[cau_pkg::ST_FLAGS_LSB +: 4];
            end else if (coreWr) begin
                flagsReg <= aluFlags;
            end
        end
    end

    cau_regfile u_regfile (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .wrEn    (wrEn),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .rdAddr  (rdAddr),
        .rdData  (rdData)
    );

    // Checks on the datapath
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst || !ce);

    sequence s_core_write(cau_pkg::cau_op_type o);
        coreWr && (opReg.op == o);
    endsequence

    sequence s_mul_start;
        (coreState == cau_pkg::CORE_EXEC) && (opReg.op == cau_pkg::OP_MUL);
    endsequence

    a_copy_lo_flags: assert property (
        s_core_write(cau_pkg::OP_COPY_LO) |=> !flagsReg.c && !flagsReg.v
            && flagsReg.z == ($past(wrData) == 32'h0000_0000))
        else $error("low copy flags wrong");

    a_copy_hi_flags: assert property (
        s_core_write(cau_pkg::OP_COPY_HI) |-> wrData == srcVal
            ##1 flagsReg == $past(flagsReg))
        else $error("high copy changed flags");

    a_hi_dest_index: assert property (
        (coreState == cau_pkg::CORE_RD_DST)
            && (instrReg[15:8] == cau_pkg::HI_COPY)
            |-> rdAddr == {instrReg[7], instrReg[2:0]})
        else $error("high copy destination index wrong");

    a_hi_src_index: assert property (
        (coreState == cau_pkg::CORE_RD_SRC)
            && (instrReg[15:8] == cau_pkg::HI_COPY)
            |-> rdAddr == {instrReg[6], instrReg[5:3]})
        else $error("high copy source index wrong");

    a_mul_product: assert property (
        s_core_write(cau_pkg::OP_MUL) |-> wrData == (srcVal * dstVal)
            && wrAddr == opReg.dstIdx)
        else $error("multiply low word wrong");

    a_mul_flags: assert property (
        s_core_write(cau_pkg::OP_MUL) |=> flagsReg.n == $past(wrData[31])
            && flagsReg.c == $past(flagsReg.c))
        else $error("multiply flags wrong");

    a_mul_bounded: assert property (
        s_mul_start |-> ##[1:34] coreWr)
        else $error("multiply did not finish");

    a_invert_value: assert property (
        s_core_write(cau_pkg::OP_INV) |-> wrData == ~srcVal
            ##1 flagsReg.c == $past(flagsReg.c)
            && flagsReg.v == $past(flagsReg.v))
        else $error("invert result or flags wrong");

    a_negate_flags: assert property (
        s_core_write(cau_pkg::OP_NEG) |-> wrData == -srcVal
            ##1 flagsReg.c == ($past(srcVal) == 32'h0000_0000)
            && flagsReg.v == ($past(srcVal[31]) && $past(wrData[31])))
        else $error("negate result or flags wrong");

    a_union_value: assert property (
        s_core_write(cau_pkg::OP_OR) |-> wrData == (rdData | srcVal)
            ##1 flagsReg.c == $past(flagsReg.c)
            && flagsReg.v == $past(flagsReg.v))
        else $error("OR result or flags wrong");

    a_decode_match: assert property (
        (coreState == cau_pkg::CORE_RD_SRC) |-> opReg == decodeInstr(instrReg))
        else $error("decoded operation mismatch");

endmodule : cau_top
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the compact ALU execute block.
// Assumes the block's AHB-Lite slave is the only device on the bus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Bench-driven inputs, all given a value at time zero
    logic        sysClk = 1'b0;
    logic        rst    = 1'b1;
    logic        ce     = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    // Design outputs; hreadyout doubles as the bus hready
    logic        hreadyOut;
    logic [31:0] hrdata;
    logic        hresp;
    // Bookkeeping
    int          errTotal = 0;
    int          nTests   = 0;
    int          cycles   = 0;
    logic [31:0] q;
    // Transfer size for the next call; word unless a test says otherwise
    logic [2:0]  xSize    = cau_pkg::SIZE_WORD;

    always #5 sysClk = ~sysClk;

    cau_top cau_top_i (
        .sys_clk(sysClk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyOut), .hreadyout(hreadyOut), .hrdata(hrdata),
        .hresp(hresp));

    // Verdict and end of run
    task automatic stopTest();
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stopTest

    // Hang guard: the whole sequence needs well under 2000 cycles
    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errTotal++;
            $display("MISMATCH t=%0t timeout", $time);
            stopTest();
        end
    end

    task automatic check(input logic [31:0] seen, exp, input string msg);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen,
                     exp);
        end
    endtask : check

    // Reads hready before the edge's own updates land
    task automatic waitReady();
        do @(posedge sysClk); while (hreadyOut !== 1'b1);
    endtask : waitReady

    // One single transfer of size xSize; the master never assumes a latency
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= xSize;
        waitReady();
        htrans <= 2'b00;
        hwdata <= d;
        waitReady();
        r = hrdata;
        check({31'h0, hresp}, {31'h0, cau_pkg::RESP_OKAY}, "resp");
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    // Preload operands and flags, execute, then read result and status
    task automatic runOp(input logic [15:0] ins, input logic [3:0] d, s,
                         input logic [31:0] dv, sv, input logic [3:0] pre,
                         input logic [31:0] res, input logic [3:0] fl);
        wr(cau_pkg::OFS_REGSEL, {28'h0, d});
        wr(cau_pkg::OFS_REGDATA, dv);
        wr(cau_pkg::OFS_REGSEL, {28'h0, s});
        wr(cau_pkg::OFS_REGDATA, sv);
        wr(cau_pkg::OFS_STATUS, {28'h0, pre});
        wr(cau_pkg::OFS_INSTR, {16'h0, ins});
        wr(cau_pkg::OFS_REGSEL, {28'h0, d});
        xfer(1'b0, cau_pkg::OFS_REGDATA, 32'h0, q);
        check(q, res, "result");
        xfer(1'b0, cau_pkg::OFS_STATUS, 32'h0, q);
        check({26'h0, q[5:0]}, {28'h0, fl}, "status");
        $display("op %h done", ins);
    endtask : runOp

    // Encoders for the three instruction forms
    function automatic logic [15:0] lo(input logic [2:0] s, d);
        return {cau_pkg::LO_COPY, s, d};
    endfunction : lo
    function automatic logic [15:0] hi(input logic [1:0] h,
                                       input logic [2:0] s, d);
        return {cau_pkg::HI_COPY, h, s, d};
    endfunction : hi
    function automatic logic [15:0] dp(input logic [3:0] op,
                                       input logic [2:0] s, d);
        return {cau_pkg::DP_GROUP, op, s, d};
    endfunction : dp

    // Main sequence
    initial begin
        repeat (20) @(posedge sysClk);
        rst <= 1'b0;
        @(posedge sysClk);
        // Reset values, then an unmapped place that ignores writes
        xfer(1'b0, cau_pkg::OFS_STATUS, 32'h0, q);
        check(q, 32'h0000_0000, "status reset");
        xfer(1'b0, cau_pkg::OFS_INSTR, 32'h0, q);
        check(q, 32'h0000_0000, "instr reset");
        wr(8'h10, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h10, 32'h0, q);
        check(q, 32'h0000_0000, "unmapped");
        $display("reset and map test done");
        // Copies
        runOp(lo(1, 2), 2, 1, 0, 32'h8000_0000, 4'h3, 32'h8000_0000,
              4'h8);
        runOp(lo(3, 3), 3, 3, 0, 0, 4'hF, 0, 4'h4);
        runOp(hi(2'b11, 1, 7), 15, 9, 1, 0, 4'hA, 0, 4'hA);
        runOp(hi(2'b01, 6, 3), 3, 14, 1, 32'h55, 4'h1, 32'h55,
              4'h1);
        runOp(hi(2'b00, 5, 4), 4, 5, 1, 32'h8000_0000, 4'h5, 32'h8000_0000,
              4'h5);
        // Multiply: signed view, same register, early and late stop
        runOp(dp(cau_pkg::OPC_MUL, 2, 1), 1, 2, 32'hFFFF_FFFF, 3, 4'h3,
              32'hFFFF_FFFD, 4'hB);
        runOp(dp(cau_pkg::OPC_MUL, 6, 6), 6, 6, 32'h1_0000, 32'h1_0000,
              4'h2, 0, 4'h6);
        runOp(dp(cau_pkg::OPC_MUL, 2, 1), 1, 2, 0, 32'h1_2345, 4'h0, 0,
              4'h4);
        runOp(dp(cau_pkg::OPC_MUL, 2, 1), 1, 2, 32'h8000_0000, 3, 4'h1,
              32'h8000_0000, 4'h9);
        // Invert, negate and OR
        runOp(dp(cau_pkg::OPC_INV, 2, 1), 1, 2, 5, 32'hFFFF_FFFF, 4'h3, 0,
              4'h7);
        runOp(dp(cau_pkg::OPC_INV, 2, 1), 1, 2, 5, 0, 4'h0, 32'hFFFF_FFFF,
              4'h8);
        runOp(dp(cau_pkg::OPC_NEG, 2, 1), 1, 2, 5, 0, 4'h8, 0,
              4'h6);
        runOp(dp(cau_pkg::OPC_NEG, 2, 1), 1, 2, 5, 32'h8000_0000, 4'h6,
              32'h8000_0000, 4'h9);
        runOp(dp(cau_pkg::OPC_NEG, 2, 1), 1, 2, 5, 1, 4'h7, 32'hFFFF_FFFF,
              4'h8);
        runOp(dp(cau_pkg::OPC_OR, 2, 1), 1, 2, 32'h0F0F_0000,
              32'h8000_0001, 4'h3, 32'h8F0F_0001, 4'hB);
        runOp(dp(cau_pkg::OPC_OR, 2, 1), 1, 2, 0, 0, 4'hB, 0,
              4'h7);
        // Unrecognised encoding sets the sticky bit; write one clears it
        wr(cau_pkg::OFS_INSTR, 32'h0000_FFFF);
        xfer(1'b0, cau_pkg::OFS_STATUS, 32'h0, q);
        check({26'h0, q[5:0]}, 32'h0000_0027, "undef set");
        wr(cau_pkg::OFS_STATUS, 32'h0000_0020);
        xfer(1'b0, cau_pkg::OFS_STATUS, 32'h0, q);
        check({26'h0, q[5:0]}, 32'h0000_0000, "undef clr");
        $display("undefined encoding test done");
        // Non-word writes are ignored; REGSEL still holds 1 from the last op
        xSize = 3'h0;
        wr(cau_pkg::OFS_REGSEL, 32'h0000_0005);
        xSize = cau_pkg::SIZE_WORD;
        xfer(1'b0, cau_pkg::OFS_REGSEL, 32'h0, q);
        check(q, 32'h0000_0001, "byte write ignored");
        // Mid-run reset returns flags, sticky bit and index to zero
        wr(cau_pkg::OFS_STATUS, 32'h0000_000F);
        wr(cau_pkg::OFS_INSTR, 32'h0000_FFFF);
        rst <= 1'b1;
        repeat (2) @(posedge sysClk);
        rst <= 1'b0;
        @(posedge sysClk);
        xfer(1'b0, cau_pkg::OFS_STATUS, 32'h0, q);
        check(q, 32'h0000_0000, "status after reset");
        xfer(1'b0, cau_pkg::OFS_REGSEL, 32'h0, q);
        check(q, 32'h0000_0000, "regsel after reset");
        $display("size and reset test done");
        stopTest();
    end
endmodule : testbench
`default_nettype wire
